// ==== core/mpw_top.sv ====
// multi-channel pulse width modulator with apb registers and shared port pins
`timescale 1ns/1ps
`default_nettype none
`include "mpw_consts.svh"

module mpw_top
  import mpw_pkg::*;
(
  // clock and reset
  input  wire logic                    pclk,
  input  wire logic                    presetn,
  // apb slave
  input  wire logic                    psel,
  input  wire logic                    penable,
  input  wire logic                    pwrite,
  input  wire logic [`MPW_ADDR_W-1:0]  paddr,
  input  wire logic [31:0]             pwdata,
  input  wire logic [3:0]              pstrb,
  output logic      [31:0]             prdata,
  output logic                         pready,
  output logic                         pslverr,
  // interrupt
  output logic                         irq,
  // shared port pins
  output mpw_pkg::mpw_pins_t           pins
);
  import mpw_pkg::*;

  // bus phase decode
  logic                        setup;
  logic                        access;
  logic                        wr;
  logic                        mapped;
  logic [31:0]                 next_prdata;

  // registers
  logic [7:0]                  pulse_ctrl_reg;
  logic [7:0]                  latch_select_field;
  logic [`MPW_IRQ_W-1:0]       irq_stat;
  logic [`MPW_IRQ_W-1:0]       irq_mask;
  logic [9:0]                  port_latch;
  logic [9:0]                  port_dir;

  // staging latches behind the data buffer
  logic [`MPW_FINE_LO_W-1:0]   stage_lo;
  logic [`MPW_FINE_HI_W-1:0]   stage_hi;
  logic [`MPW_COARSE_W-1:0]    stage_c [1:`MPW_COARSE];

  // transfer machine
  mpw_state_t                  state;
  logic [7:0]                  target;
  logic                        transfer_pending_flag;
  logic                        xfer_req;
  logic                        data_wr;
  logic                        refuse;
  logic                        done;
  logic                        load_fine;
  logic [`MPW_COARSE:1]        load_c;

  // timing and channel levels
  logic [`MPW_MAIN_CNT_W-1:0]  cnt;
  logic [`MPW_CHANNELS-1:0]    active;
  logic [7:0]                  pulse_status_reg;
  logic [7:0]                  pulse_data_buffer;

  assign setup  = psel && !penable;
  assign access = psel && penable && pready;
  assign wr     = access && pwrite && pstrb[0] && !pslverr;

  always_comb
  begin
    if (paddr == `MPW_CTRL_ADDR)
      mapped = 1'b1;
    else if (paddr == `MPW_DATA_ADDR)
      mapped = 1'b1;
    else if (paddr == `MPW_STATUS_ADDR)
      mapped = 1'b1;
    else if (paddr == `MPW_IRQ_STAT_ADDR)
      mapped = 1'b1;
    else if (paddr == `MPW_IRQ_MASK_ADDR)
      mapped = 1'b1;
    else if (paddr == `MPW_PORT_LATCH_ADDR)
      mapped = 1'b1;
    else if (paddr == `MPW_PORT_DIR_ADDR)
      mapped = 1'b1;
    else
      mapped = 1'b0;
  end

  // readback of the data buffer shows the slot under the current select
  always_comb
  begin
    pulse_data_buffer = 8'h00;
    if (latch_select_field == `MPW_SEL_FINE_LO)
      pulse_data_buffer = {2'b00, stage_lo};
    else if (latch_select_field == `MPW_SEL_FINE_HI)
      pulse_data_buffer = stage_hi;
    else if (latch_select_field >= `MPW_SEL_COARSE_1ST && latch_select_field <= `MPW_SEL_COARSE_LAST)
      pulse_data_buffer = {1'b0, stage_c[latch_select_field - 8'h01]};
  end

  always_comb
  begin
    pulse_status_reg = 8'h00;
    pulse_status_reg[`MPW_PEND_BIT] = transfer_pending_flag;
  end

  always_comb
  begin
    if (paddr == `MPW_CTRL_ADDR)
      next_prdata = {24'h000000, pulse_ctrl_reg};
    else if (paddr == `MPW_DATA_ADDR)
      next_prdata = {24'h000000, pulse_data_buffer};
    else if (paddr == `MPW_STATUS_ADDR)
      next_prdata = {24'h000000, pulse_status_reg};
    else if (paddr == `MPW_IRQ_STAT_ADDR)
      next_prdata = {30'h0, irq_stat};
    else if (paddr == `MPW_IRQ_MASK_ADDR)
      next_prdata = {30'h0, irq_mask};
    else if (paddr == `MPW_PORT_LATCH_ADDR)
      next_prdata = {22'h0, port_latch};
    else if (paddr == `MPW_PORT_DIR_ADDR)
      next_prdata = {22'h0, port_dir};
    else
      next_prdata = 32'h00000000;
  end

  // answer in the cycle after setup: no wait states, all outputs registered
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end
    else
    begin
      pready  <= setup;
      pslverr <= setup && !mapped;
      if (setup && !pwrite)
        prdata <= next_prdata;
    end
  end

  // control register; the last non-request code stays as latch select
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pulse_ctrl_reg     <= `MPW_CTRL_RST;
      latch_select_field <= `MPW_CTRL_RST;
    end
    else if (wr && paddr == `MPW_CTRL_ADDR)
    begin
      pulse_ctrl_reg <= pwdata[7:0];
      if (pwdata[7:0] != `MPW_CMD_XFER)
        latch_select_field <= pwdata[7:0];
    end
  end

  assign xfer_req = wr && paddr == `MPW_CTRL_ADDR && pwdata[7:0] == `MPW_CMD_XFER;
  assign data_wr  = wr && paddr == `MPW_DATA_ADDR;
  // data written during a transfer is dropped, protecting the staged value
  assign refuse   = transfer_pending_flag && (data_wr || xfer_req);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      stage_lo <= '0;
      stage_hi <= '0;
    end
    else if (data_wr && !transfer_pending_flag)
    begin
      if (latch_select_field == `MPW_SEL_FINE_LO)
        stage_lo <= pwdata[`MPW_FINE_LO_W-1:0];
      else if (latch_select_field == `MPW_SEL_FINE_HI)
        stage_hi <= pwdata[`MPW_FINE_HI_W-1:0];
    end
  end

  // free-running timebase shared by all channels
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cnt <= '0;
    else
      cnt <= cnt + 15'h0001;
  end

  // transfer machine: pending from the request until the latch is loaded
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state  <= MPW_ST_IDLE;
      target <= `MPW_CTRL_RST;
    end
    else
    begin
      case (state)
        MPW_ST_IDLE:
        begin
          if (xfer_req)
          begin
            state  <= MPW_ST_WAIT;
            target <= latch_select_field;
          end
        end
        MPW_ST_WAIT:
        begin
          if (done)
            state <= MPW_ST_IDLE;
        end
        default:
          state <= MPW_ST_IDLE;
      endcase
    end
  end

  assign transfer_pending_flag = (state == MPW_ST_WAIT);

  // channel zero loads only in the last cycle of its main period
  assign load_fine = transfer_pending_flag && target <= `MPW_SEL_FINE_HI
                     && cnt == `MPW_MAIN_LAST;

  // an unmapped select has no latch, so its request ends at once
  always_comb
  begin
    done = 1'b0;
    if (transfer_pending_flag)
    begin
      if (target <= `MPW_SEL_FINE_HI)
        done = load_fine;
      else if (target <= `MPW_SEL_COARSE_LAST)
        done = |load_c;
      else
        done = 1'b1;
    end
  end

  // staging, load strobe and generator for each 7-bit channel
  genvar gi;
  generate
    for (gi = 1; gi <= `MPW_COARSE; gi++)
    begin : g_coarse
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
          stage_c[gi] <= '0;
        else if (data_wr && !transfer_pending_flag && latch_select_field == 8'(gi + 1))
          stage_c[gi] <= pwdata[`MPW_COARSE_W-1:0];
      end

      assign load_c[gi] = transfer_pending_flag && target == 8'(gi + 1)
                          && cnt[`MPW_SHORT_POS_MSB:0] == `MPW_SHORT_LAST;

      mpw_coarse_chan u_chan (
        .pclk    (pclk),
        .presetn (presetn),
        .cnt_lo  (cnt[`MPW_SHORT_POS_MSB:0]),
        .load    (load_c[gi]),
        .data    (stage_c[gi]),
        .active  (active[gi])
      );
    end
  endgenerate

  mpw_fine_chan u_fine_channel_zero (
    .pclk    (pclk),
    .presetn (presetn),
    .cnt     (cnt),
    .load    (load_fine),
    .data    ({stage_hi, stage_lo}),
    .active  (active[0])
  );

  // port latch and direction bits that own the shared pins
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      port_latch <= `MPW_PORT_RST;
      port_dir   <= `MPW_PORT_RST;
    end
    else if (wr && paddr == `MPW_PORT_LATCH_ADDR)
      port_latch <= pwdata[9:0];
    else if (wr && paddr == `MPW_PORT_DIR_ADDR)
      port_dir <= pwdata[9:0];
  end

  // with latch low the pin just drives the latch level, never the pulse
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pins.dout <= '0;
      pins.doe  <= '0;
    end
    else
    begin
      pins.dout <= port_latch & ~active;
      pins.doe  <= port_dir;
    end
  end

  // sticky events: a set in the same cycle as a clear is kept
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      irq_stat <= '0;
    else
    begin
      irq_stat[`MPW_IRQ_DONE_BIT] <= (irq_stat[`MPW_IRQ_DONE_BIT]
        & ~(wr && paddr == `MPW_IRQ_STAT_ADDR && pwdata[`MPW_IRQ_DONE_BIT])) | done;
      irq_stat[`MPW_IRQ_REFUSE_BIT] <= (irq_stat[`MPW_IRQ_REFUSE_BIT]
        & ~(wr && paddr == `MPW_IRQ_STAT_ADDR && pwdata[`MPW_IRQ_REFUSE_BIT])) | refuse;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      irq_mask <= '0;
    else if (wr && paddr == `MPW_IRQ_MASK_ADDR)
      irq_mask <= pwdata[`MPW_IRQ_W-1:0];
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      irq <= 1'b0;
    else
      irq <= |(irq_stat & irq_mask);
  end

endmodule : mpw_top
`default_nettype wire

// ==== core/mpw_consts.svh ====
// constant names for the multi-channel pulse width modulator
`ifndef MPW_CONSTS_SVH
`define MPW_CONSTS_SVH

// register byte addresses on the apb bus
`define MPW_ADDR_W          12
`define MPW_CTRL_ADDR       12'h000
`define MPW_DATA_ADDR       12'h004
`define MPW_STATUS_ADDR     12'h008
`define MPW_IRQ_STAT_ADDR   12'h00C
`define MPW_IRQ_MASK_ADDR   12'h010
`define MPW_PORT_LATCH_ADDR 12'h014
`define MPW_PORT_DIR_ADDR   12'h018

// latch select codes and the transfer request code
`define MPW_SEL_FINE_LO     8'h00
`define MPW_SEL_FINE_HI     8'h01
`define MPW_SEL_COARSE_1ST  8'h02
`define MPW_SEL_COARSE_LAST 8'h0A
`define MPW_CMD_XFER        8'h0C

// status and interrupt bit positions
`define MPW_PEND_BIT        7
`define MPW_IRQ_DONE_BIT    0
`define MPW_IRQ_REFUSE_BIT  1
`define MPW_IRQ_W           2

// channel counts and widths
`define MPW_CHANNELS        10
`define MPW_COARSE          9
`define MPW_FINE_LO_W       6
`define MPW_FINE_HI_W       8
`define MPW_FINE_W          14
`define MPW_COARSE_W        7

// timing in clock cycles: main period 2^15, short period 2^8, unit two cycles
`define MPW_MAIN_CNT_W      15
`define MPW_MAIN_LAST       15'h7FFF
`define MPW_SHORT_LAST      8'hFF
`define MPW_SUB_MSB         14
`define MPW_SUB_LSB         9
`define MPW_POS_MSB         8
`define MPW_POS_LSB         1
`define MPW_SHORT_POS_MSB   7

// reset values
`define MPW_CTRL_RST        8'h00
`define MPW_PORT_RST        10'h000

`endif

// ==== core/mpw_pkg.sv ====
// types shared by the pulse width modulator files
package mpw_pkg;

  // one bundle for the ten shared port pins
  typedef struct packed {
    logic [9:0] dout;
    logic [9:0] doe;
  } mpw_pins_t;

  // transfer state, one-hot
  typedef enum logic [1:0] {
    MPW_ST_IDLE = 2'b01,
    MPW_ST_WAIT = 2'b10
  } mpw_state_t;

endpackage : mpw_pkg

// ==== core/mpw_coarse_chan.sv ====
// one 7-bit channel with a 256-cycle period
`timescale 1ns/1ps
`default_nettype none
`include "mpw_consts.svh"

module mpw_coarse_chan
  import mpw_pkg::*;
(
  // clock and reset
  input  wire logic                     pclk,
  input  wire logic                     presetn,
  // timing and load
  input  wire logic [7:0]               cnt_lo,
  input  wire logic                     load,
  input  wire logic [`MPW_COARSE_W-1:0] data,
  // modulated level, high while the pulse is on
  output logic                          active
);
  import mpw_pkg::*;

  logic [`MPW_COARSE_W-1:0] width;

  // load only ever arrives in the last cycle of a period
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      width <= '0;
    else if (load)
      width <= data;
  end

  // pulse of k units of two cycles per 256-cycle period
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      active <= 1'b0;
    else
      active <= (cnt_lo[`MPW_SHORT_POS_MSB:`MPW_POS_LSB] < width);
  end

endmodule : mpw_coarse_chan
`default_nettype wire

// ==== core/mpw_fine_chan.sv ====
// 14-bit channel zero: base width per sub-period plus spread extra pulses
`timescale 1ns/1ps
`default_nettype none
`include "mpw_consts.svh"

module mpw_fine_chan
  import mpw_pkg::*;
(
  // clock and reset
  input  wire logic                        pclk,
  input  wire logic                        presetn,
  // timing and load
  input  wire logic [`MPW_MAIN_CNT_W-1:0]  cnt,
  input  wire logic                        load,
  input  wire logic [`MPW_FINE_W-1:0]      data,
  // modulated level, high while the pulse is on
  output logic                             active
);
  import mpw_pkg::*;

  logic [`MPW_FINE_W-1:0]    width;
  logic [5:0]                sub;
  logic [7:0]                pos;
  logic [`MPW_FINE_HI_W-1:0] base;
  logic [`MPW_FINE_LO_W-1:0] extra;
  logic                      add;

  assign sub   = cnt[`MPW_SUB_MSB:`MPW_SUB_LSB];
  assign pos   = cnt[`MPW_POS_MSB:`MPW_POS_LSB];
  assign base  = width[`MPW_FINE_W-1:`MPW_FINE_LO_W];
  assign extra = width[`MPW_FINE_LO_W-1:0];

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      width <= '0;
    else if (load)
      width <= data;
  end

  // the lowest set bit of the sub-period index picks the extra bit,
  // so bit j covers 2^j sub-periods and m of 64 get one more unit
  always_comb
  begin
    if (sub[0])
      add = extra[5];
    else if (sub[1])
      add = extra[4];
    else if (sub[2])
      add = extra[3];
    else if (sub[3])
      add = extra[2];
    else if (sub[4])
      add = extra[1];
    else if (sub[5])
      add = extra[0];
    else
      add = 1'b0;
  end

  // nine-bit compare lets 255 plus an extra unit fill the whole sub-period
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      active <= 1'b0;
    else
      active <= ({1'b0, pos} < ({1'b0, base} + {8'h00, add}));
  end

endmodule : mpw_fine_chan
`default_nettype wire

// ==== sim/mpw_lpf_model.sv ====
// external low-pass filter model: driven-low cycle totals per pin
`timescale 1ns/1ps
`default_nettype none

module mpw_lpf_model
(
  // clock and window restart
  input  wire logic               pclk,
  input  wire logic               clr,
  // shared port pins
  input  wire mpw_pkg::mpw_pins_t pins,
  // filter charge as low-cycle totals
  output logic [9:0][15:0]        low_cnt
);
  import mpw_pkg::*;

  // a released pin is ignored, only a driven low pulls the filter down
  always_ff @(posedge pclk)
  begin
    for (int i = 0; i < 10; i++)
      if (clr)
        low_cnt[i] <= 16'h0000;
      else if (pins.doe[i] && !pins.dout[i])
        low_cnt[i] <= low_cnt[i] + 16'h0001;
  end
endmodule : mpw_lpf_model

`default_nettype wire

// ==== sim/mpw_top_asserts.sv ====
// concurrent checks on the apb port and shared pins of the modulator
`timescale 1ns/1ps
`default_nettype none
`include "mpw_consts.svh"

module mpw_top_asserts
(
  // watched ports
  input wire logic               pclk,
  input wire logic               presetn,
  input wire logic               psel,
  input wire logic               penable,
  input wire logic               pwrite,
  input wire logic [11:0]        paddr,
  input wire logic [31:0]        pwdata,
  input wire logic [3:0]         pstrb,
  input wire logic [31:0]        prdata,
  input wire logic               pready,
  input wire logic               pslverr,
  input wire logic               irq,
  input wire mpw_pkg::mpw_pins_t pins
);
  import mpw_pkg::*;
  logic [8:0] gap0;
  logic [7:0] gap1;
  logic       seen0;
  logic       seen1;
  logic       wacc;
  logic       latw;
  logic [9:0] wlo;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  assign wacc = psel && penable && pready && pwrite && pstrb[0];
  assign latw = wacc && paddr == `MPW_PORT_LATCH_ADDR;
  assign wlo  = pwdata[9:0];

  // cycles since last fall; a latch write can make a fall off the period grid
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      gap0 <= 9'h000;
      gap1 <= 8'h00;
      seen0 <= 1'b0;
      seen1 <= 1'b0;
    end
    else
    begin
      gap0 <= $fell(pins.dout[0]) ? 9'h001 : gap0 + 9'h001;
      gap1 <= $fell(pins.dout[1]) ? 8'h01 : gap1 + 8'h01;
      seen0 <= ($fell(pins.dout[0]) || seen0) && !latw;
      seen1 <= ($fell(pins.dout[1]) || seen1) && !latw;
    end
  end

  property p_ready_next;
    psel && !penable |=> pready;
  endproperty
  a_ready_next: assert property (p_ready_next) else $error("no ready after setup");

  property p_ready_once;
    pready |=> !pready;
  endproperty
  a_ready_once: assert property (p_ready_once) else $error("ready held too long");

  property p_err_unmapped;
    psel && !penable && paddr > `MPW_PORT_DIR_ADDR |=> pready && pslverr;
  endproperty
  a_err_unmapped: assert property (p_err_unmapped) else $error("unmapped access not refused");

  property p_err_mapped;
    psel && !penable && paddr <= `MPW_PORT_DIR_ADDR && paddr[1:0] == 2'h0 |=> !pslverr;
  endproperty
  a_err_mapped: assert property (p_err_mapped) else $error("mapped access refused");

  property p_dir_out;
    wacc && paddr == `MPW_PORT_DIR_ADDR |-> ##2 pins.doe == $past(wlo, 2);
  endproperty
  a_dir_out: assert property (p_dir_out) else $error("pin enables differ from direction");

  property p_latch_gate;
    latw |-> ##2 (pins.dout & ~$past(wlo, 2)) == 10'h000;
  endproperty
  a_latch_gate: assert property (p_latch_gate) else $error("pin high with latch clear");

  property p_irq_masked;
    wacc && paddr == `MPW_IRQ_MASK_ADDR && wlo[1:0] == 2'h0 |-> ##2 !irq;
  endproperty
  a_irq_masked: assert property (p_irq_masked) else $error("interrupt with mask clear");

  property p_ch1_period;
    $fell(pins.dout[1]) && seen1 |-> gap1 == 8'h00;
  endproperty
  a_ch1_period: assert property (p_ch1_period) else $error("channel one pulse off period");

  property p_ch0_sub;
    $fell(pins.dout[0]) && seen0 |-> gap0 == 9'h000;
  endproperty
  a_ch0_sub: assert property (p_ch0_sub) else $error("channel zero pulse off sub-period");
endmodule : mpw_top_asserts

bind mpw_top mpw_top_asserts u_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .irq(irq), .pins(pins));

`default_nettype wire

// ==== sim/mpw_top_tb.sv ====
// self-checking bench: apb tasks, channel updates and filter totals
`timescale 1ns/1ps
`default_nettype none
`include "mpw_consts.svh"

module mpw_top_tb;
  import mpw_pkg::*;
  logic             pclk;
  logic             presetn;
  logic             psel;
  logic             penable;
  logic             pwrite;
  logic [11:0]      paddr;
  logic [31:0]      pwdata;
  logic [3:0]       pstrb;
  logic [31:0]      prdata;
  logic             pready;
  logic             pslverr;
  logic             irq;
  mpw_pins_t        pins;
  logic             clr;
  logic [9:0][15:0] low_cnt;
  logic [31:0]      q;
  logic             e;
  int               fails = 0;
  int               checked = 0;
  int               cyc = 0;

  mpw_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq(irq), .pins(pins));
  mpw_lpf_model u_lpf (.pclk(pclk), .clr(clr), .pins(pins), .low_cnt(low_cnt));

  initial
  begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  task end_of_test;
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : end_of_test

  task chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      fails++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // pready, prdata and pslverr are taken at the rising edge that ends the access;
  // the leading edge wait keeps back-to-back calls from assigning psel twice in one step
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d, output logic [31:0] rd,
           output logic err);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task poll(input int lim);
    int t0;
    t0 = cyc;
    q = 32'h80;
    while (q[7] === 1'b1 && cyc - t0 < lim)
      apb(1'b0, `MPW_STATUS_ADDR, 32'h0, q, e);
    chk(q & 32'h80, 32'h0);
  endtask : poll

  always @(posedge pclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 90000)
    begin
      fails++;
      end_of_test();
    end
  end

  initial
  begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    pstrb = 4'hF;
    clr = 1'b0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    for (int a = 0; a <= 24; a += 4)
    begin
      apb(1'b0, 12'(a), 32'h0, q, e);
      chk(q, 32'h0);
    end
    apb(1'b0, 12'h01C, 32'h0, q, e);
    chk({q[31:1], e}, 32'h1);
    apb(1'b1, `MPW_PORT_LATCH_ADDR, 32'h3FF, q, e);
    apb(1'b1, `MPW_PORT_DIR_ADDR, 32'h3FF, q, e);
    apb(1'b1, `MPW_IRQ_MASK_ADDR, 32'h1, q, e);
    @(negedge pclk);
    chk({22'h0, pins.doe}, 32'h3FF);
    chk({22'h0, pins.dout}, 32'h3FF);
    // channel zero: m = 5 gives five extra units, n = 128
    apb(1'b1, `MPW_CTRL_ADDR, 32'h0, q, e);
    apb(1'b1, `MPW_DATA_ADDR, 32'h5, q, e);
    apb(1'b1, `MPW_CTRL_ADDR, 32'h1, q, e);
    apb(1'b1, `MPW_DATA_ADDR, 32'h80, q, e);
    apb(1'b1, `MPW_CTRL_ADDR, 32'hC, q, e);
    apb(1'b0, `MPW_STATUS_ADDR, 32'h0, q, e);
    chk(q, 32'h80);
    apb(1'b1, `MPW_DATA_ADDR, 32'hFF, q, e);
    apb(1'b0, `MPW_IRQ_STAT_ADDR, 32'h0, q, e);
    chk({q[30:0], irq}, 32'h4);
    poll(32800);
    @(negedge pclk);
    chk({31'h0, irq}, 32'h1);
    apb(1'b1, `MPW_IRQ_STAT_ADDR, 32'h3, q, e);
    apb(1'b0, `MPW_IRQ_STAT_ADDR, 32'h0, q, e);
    chk({q[30:0], irq}, 32'h0);
    for (int i = 1; i < 10; i++)
    begin
      apb(1'b1, `MPW_CTRL_ADDR, 32'(i + 1), q, e);
      apb(1'b1, `MPW_DATA_ADDR, 32'(i * 13), q, e);
      apb(1'b0, `MPW_DATA_ADDR, 32'h0, q, e);
      chk(q, 32'(i * 13));
      apb(1'b1, `MPW_CTRL_ADDR, 32'hC, q, e);
      poll(528);
    end
    @(negedge pclk);
    chk({31'h0, irq}, 32'h1);
    apb(1'b1, `MPW_IRQ_MASK_ADDR, 32'h0, q, e);
    repeat (3) @(posedge pclk);
    chk({31'h0, irq}, 32'h0);
    // the window is a whole number of periods, so its start phase does not matter
    repeat (600) @(posedge pclk);
    clr <= 1'b1;
    @(posedge pclk);
    clr <= 1'b0;
    repeat (32768) @(posedge pclk);
    @(negedge pclk);
    chk(32'(low_cnt[0]), 32'h400A);
    for (int i = 1; i < 10; i++)
      chk(32'(low_cnt[i]), 32'(i * 13 * 256));
    apb(1'b1, `MPW_PORT_LATCH_ADDR, 32'h0, q, e);
    repeat (3) @(posedge pclk);
    chk({22'h0, pins.dout}, 32'h0);
    end_of_test();
  end
endmodule : mpw_top_tb

`default_nettype wire
